// file: alsr_consts.svh
// Purpose: shared constants for the analog lane setting reconfiguration block
// Assumes: four channels, 10 MHz controller clock
// Notes: offsets are byte addresses on the register bus
`ifndef ALSR_CONSTS_SVH
`define ALSR_CONSTS_SVH

// channel count and index width
`define ALSR_NCH 4
`define ALSR_IDX_W 2
// analog control field widths (fixed, not per channel)
`define ALSR_SWING_W 3
`define ALSR_PREEMP_W 5
`define ALSR_DCG_W 2
`define ALSR_EQ_W 4
// packed setting word layout
`define ALSR_SET_W 14
`define ALSR_SWING_LSB 11
`define ALSR_PREEMP_LSB 6
`define ALSR_DCG_LSB 4
`define ALSR_EQ_LSB 0
`define ALSR_SET_RST 14'h0000
// direction select codes
`define ALSR_DIR_RX 2'h1
`define ALSR_DIR_TX 2'h2
// timing counts: offset window and tick divider in controller clock cycles, transfer length in divider steps
`define ALSR_OC_LAST 5'h0F
`define ALSR_TICK_DIV 3'h4
`define ALSR_XFER_LAST 3'h3
// register offsets
`define ALSR_OFF_CTRL 8'h00
`define ALSR_OFF_STATUS 8'h04
`define ALSR_OFF_WRCNT 8'h08
`define ALSR_OFF_RDCNT 8'h0C
`define ALSR_CTRL_RST 1'h1
// bus responses
`define ALSR_RESP_OKAY 2'h0
`define ALSR_RESP_SLVERR 2'h2

`endif

// file: alsr_pkg.sv
// Purpose: types for the analog lane setting reconfiguration block
// Assumes: nothing beyond the constants header
// Notes: state codes are written out
package alsr_pkg;
  // controller sequencing states
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_OFFSET = 3'h1,
    ST_IDLE = 3'h2,
    ST_WR = 3'h3,
    ST_RD = 3'h4
  } alsr_state_t;
endpackage

// file: alsr_tick_div.sv
// Purpose: step enable divider for channel transfers
// Assumes: single clock
// Notes: clear restarts the phase so every transfer has the same length
`timescale 1ns/1ps
`include "alsr_consts.svh"
module alsr_tick_div (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_clr,
  // one-cycle enable
  output logic o_tick
);
  logic [2:0] cnt_q; // phase counter

  // count up, pulse on wrap
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 3'h0;
      o_tick <= 1'b0;
    end else if (i_clr) begin
      cnt_q <= 3'h0;
      o_tick <= 1'b0;
    end else if (cnt_q == `ALSR_TICK_DIV - 3'h1) begin
      cnt_q <= 3'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      o_tick <= 1'b0;
    end
  end
endmodule // alsr_tick_div

// file: alsr_set_mem.sv
// Purpose: per-channel analog setting store
// Assumes: one read and one write port on the same address
// Notes: read data is registered, one cycle behind the address
`timescale 1ns/1ps
`include "alsr_consts.svh"
module alsr_set_mem (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // access
  input wire logic i_we,
  input wire logic [`ALSR_IDX_W-1:0] i_addr,
  input wire logic [`ALSR_SET_W-1:0] i_wdata,
  output logic [`ALSR_SET_W-1:0] o_rdata
);
  logic [`ALSR_SET_W-1:0] mem_q [`ALSR_NCH]; // one word per channel

  // each entry is a resettable register so reset clears all settings
  for (genvar g = 0; g < `ALSR_NCH; g++) begin : g_ent
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mem_q[g] <= `ALSR_SET_RST;
      end else if (i_we && (i_addr == `ALSR_IDX_W'(g))) begin
        mem_q[g] <= i_wdata;
      end
    end
  end

  // registered read
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `ALSR_SET_RST;
    end else begin
      o_rdata <= mem_q[i_addr];
    end
  end
endmodule // alsr_set_mem

// file: alsr_reconfig.sv
// Purpose: channel-addressed analog setting write/read controller
// Assumes: fabric requester synchronous to i_sys_clk, AXI4-Lite register access
// Notes: the touched channel only is modified; other channels keep running
`timescale 1ns/1ps
`include "alsr_consts.svh"

// Operation
// R01: swing ports 3 bits, pre-emphasis 5 bits
// R02: dc gain 2 bits, equalization 4 bits
// R03: channel addressing needs multiple channels
// R04: select 2'b10 touches transmit controls only
// R05: select chooses receive, transmit, or both
// R06: requester holds values, index, select stable
// R07: requester sets index and select before read
// R08: requester checks busy low before starting
// R09: one-cycle write or read strobe starts
// R10: busy high during write, low after
// R11: busy high during read, low after
// R12: valid flags read-back outputs after read
// R13: requester never overlaps write and read
// R14: four channels give a 2-bit index
// R15: other channels keep running during reconfiguration
// R16: controls: pre-emphasis, equalization, dc gain, swing
// R17: no self-test, direction or bonding switching
// R18: reset clears every controller register; ctrl_en_q resets to 1 and the AXI ready flags to 1
// R19: busy low one cycle, then offset cancellation
// R20: strobes during busy are ignored
module alsr_reconfig (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // fabric request
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [`ALSR_IDX_W-1:0] i_chan_idx,
  input wire logic [1:0] i_dir_sel,
  input wire logic [`ALSR_SWING_W-1:0] i_output_swing,
  input wire logic [`ALSR_PREEMP_W-1:0] i_preemp,
  input wire logic [`ALSR_DCG_W-1:0] i_dc_gain,
  input wire logic [`ALSR_EQ_W-1:0] i_rx_eq,
  // fabric answer
  output logic o_busy,
  output logic o_data_valid,
  output logic [`ALSR_SWING_W-1:0] o_output_swing,
  output logic [`ALSR_PREEMP_W-1:0] o_preemp,
  output logic [`ALSR_DCG_W-1:0] o_dc_gain,
  output logic [`ALSR_EQ_W-1:0] o_rx_eq,
  // axi write channels
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi read channels
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  import alsr_pkg::*;

  alsr_state_t state_q; // sequencer state
  logic [4:0] oc_cnt_q; // offset cancellation cycle count
  logic [2:0] xfer_cnt_q; // transfer step count
  logic tick; // step enable from divider
  logic last_step; // final step of a transfer
  logic [`ALSR_IDX_W-1:0] chan_q; // latched channel index
  logic [1:0] dir_q; // latched direction select
  logic [`ALSR_SET_W-1:0] new_q; // latched write values
  logic [`ALSR_SET_W-1:0] old_set; // stored word of the channel
  logic [`ALSR_SET_W-1:0] merged; // word to store on a write
  logic tx_on; // transfer touches transmit controls
  logic rx_on; // transfer touches receive controls
  logic mem_we; // store strobe
  logic start_ok; // a single clean strobe may start
  logic ctrl_en_q; // software gate on fabric strobes
  logic oc_done_q; // power-up cancellation finished
  logic [15:0] wr_cnt_q; // completed writes
  logic [15:0] rd_cnt_q; // completed reads
  logic [7:0] awaddr_q; // held write address
  logic [31:0] wdata_q; // held write data
  logic [3:0] wstrb_q; // held write strobes
  logic [31:0] rd_mux; // read data select
  logic [4:0] xfer_age_q; // check helper: cycles into the running transfer

  // field masks follow the select; 2'b10 leaves receive fields alone
  assign tx_on = (dir_q != `ALSR_DIR_RX); // see R04, see R05
  assign rx_on = (dir_q != `ALSR_DIR_TX); // see R04, see R05
  assign last_step = tick && (xfer_cnt_q == `ALSR_XFER_LAST);
  assign mem_we = (state_q == ST_WR) && last_step;
  // both strobes at once is a requester fault, so neither is taken
  assign start_ok = ctrl_en_q && (i_wr_stb ^ i_rd_stb); // see R09, see R13

  // read-modify-write keeps untouched fields of the addressed channel
  always_comb begin
    merged = old_set;
    if (tx_on) begin
      merged[`ALSR_SWING_LSB +: `ALSR_SWING_W] = new_q[`ALSR_SWING_LSB +: `ALSR_SWING_W];
      merged[`ALSR_PREEMP_LSB +: `ALSR_PREEMP_W] = new_q[`ALSR_PREEMP_LSB +: `ALSR_PREEMP_W];
    end
    if (rx_on) begin
      merged[`ALSR_DCG_LSB +: `ALSR_DCG_W] = new_q[`ALSR_DCG_LSB +: `ALSR_DCG_W];
      merged[`ALSR_EQ_LSB +: `ALSR_EQ_W] = new_q[`ALSR_EQ_LSB +: `ALSR_EQ_W];
    end
  end

  // settings of four channels; only one word changes per write
  alsr_set_mem u_mem (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_we(mem_we), // see R15, see R16
    .i_addr(chan_q),
    .i_wdata(merged),
    .o_rdata(old_set)
  );

  // step pacing; held clear outside transfers so every one has equal length
  alsr_tick_div u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_clr((state_q != ST_WR) && (state_q != ST_RD)),
    .o_tick(tick)
  );

  // sequencer: power-up cancellation, then single transfers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_POR; // see R18
      o_busy <= 1'b0; // see R19
      oc_cnt_q <= 5'h00;
      oc_done_q <= 1'b0;
      xfer_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        // first cycle after reset: busy stays low
        ST_POR: begin
          state_q <= ST_OFFSET;
          o_busy <= 1'b1; // see R19
        end
        // fixed-length cancellation window
        ST_OFFSET: begin
          oc_cnt_q <= oc_cnt_q + 5'h01;
          if (oc_cnt_q == `ALSR_OC_LAST) begin
            state_q <= ST_IDLE;
            o_busy <= 1'b0; // see R19
            oc_done_q <= 1'b1;
          end
        end
        // strobes only count here, so anything during busy is dropped
        ST_IDLE: begin
          xfer_cnt_q <= 3'h0;
          if (start_ok) begin
            state_q <= i_wr_stb ? ST_WR : ST_RD; // see R17, see R20
            o_busy <= 1'b1; // see R10, see R11
          end
        end
        // write or read runs a fixed number of steps
        ST_WR, ST_RD: begin
          if (tick) begin
            xfer_cnt_q <= xfer_cnt_q + 3'h1;
          end
          if (last_step) begin
            state_q <= ST_IDLE;
            o_busy <= 1'b0; // see R10, see R11
          end
        end
        default: begin
          state_q <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // request capture; latching tolerates a requester that lets go early
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chan_q <= '0;
      dir_q <= 2'h0;
      new_q <= `ALSR_SET_RST;
    end else if (state_q == ST_IDLE && start_ok) begin
      chan_q <= i_chan_idx; // see R03, see R06, see R07, see R14
      dir_q <= i_dir_sel; // see R05
      new_q <= {i_output_swing, i_preemp, i_dc_gain, i_rx_eq}; // see R01, see R02
    end
  end

  // read-back ports: only the selected portion is refreshed
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data_valid <= 1'b0;
      o_output_swing <= '0;
      o_preemp <= '0;
      o_dc_gain <= '0;
      o_rx_eq <= '0;
    end else begin
      o_data_valid <= (state_q == ST_RD) && last_step; // see R12
      if ((state_q == ST_RD) && last_step) begin
        if (tx_on) begin
          o_output_swing <= old_set[`ALSR_SWING_LSB +: `ALSR_SWING_W]; // see R04
          o_preemp <= old_set[`ALSR_PREEMP_LSB +: `ALSR_PREEMP_W];
        end
        if (rx_on) begin
          o_dc_gain <= old_set[`ALSR_DCG_LSB +: `ALSR_DCG_W];
          o_rx_eq <= old_set[`ALSR_EQ_LSB +: `ALSR_EQ_W];
        end
      end
    end
  end

  // completed transfer counters, readable by software
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_cnt_q <= 16'h0000;
      rd_cnt_q <= 16'h0000;
    end else if (last_step) begin
      if (state_q == ST_WR) begin
        wr_cnt_q <= wr_cnt_q + 16'h0001;
      end else begin
        rd_cnt_q <= rd_cnt_q + 16'h0001;
      end
    end
  end

  // axi write: address and data taken in either order, answer after both
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `ALSR_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_en_q <= `ALSR_CTRL_RST;
    end else begin
      if (o_awready && i_awvalid) begin
        o_awready <= 1'b0;
        awaddr_q <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        o_wready <= 1'b0;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      // both halves held and no answer pending: commit
      if (!o_awready && !o_wready && !o_bvalid) begin
        o_bvalid <= 1'b1;
        case (awaddr_q)
          `ALSR_OFF_CTRL: begin
            o_bresp <= `ALSR_RESP_OKAY;
            if (wstrb_q[0]) begin
              ctrl_en_q <= wdata_q[0];
            end
          end
          // status and counters ignore writes
          `ALSR_OFF_STATUS, `ALSR_OFF_WRCNT, `ALSR_OFF_RDCNT: begin
            o_bresp <= `ALSR_RESP_OKAY;
          end
          default: begin
            o_bresp <= `ALSR_RESP_SLVERR;
          end
        endcase
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // read data select; unmapped reads return zero
  always_comb begin
    case (i_araddr)
      `ALSR_OFF_CTRL: rd_mux = {31'h0, ctrl_en_q};
      `ALSR_OFF_STATUS: rd_mux = {25'h0, state_q, 2'h0, oc_done_q, o_busy};
      `ALSR_OFF_WRCNT: rd_mux = {16'h0, wr_cnt_q};
      `ALSR_OFF_RDCNT: rd_mux = {16'h0, rd_cnt_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // axi read: answer one cycle after the address is taken
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `ALSR_RESP_OKAY;
    end else if (o_arready && i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_mux;
      o_rresp <= (i_araddr[7:4] == 4'h0 && i_araddr[1:0] == 2'h0) ?
                 `ALSR_RESP_OKAY : `ALSR_RESP_SLVERR;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // check helper: transfer age, so long busy windows need no long repetition
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xfer_age_q <= 5'h00;
    end else if (state_q == ST_WR || state_q == ST_RD) begin
      xfer_age_q <= xfer_age_q + 5'h01;
    end else begin
      xfer_age_q <= 5'h00;
    end
  end

  // checks and coverage
  a_por_busy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R19
    (state_q == ST_POR) |-> !o_busy ##1 o_busy)
    else $error("busy not low then high after reset");
  a_oc_end: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R19
    (state_q == ST_OFFSET && oc_cnt_q == `ALSR_OC_LAST) |=> !o_busy && oc_done_q)
    else $error("offset window did not end on count");
  a_wr_busy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R10
    (state_q == ST_IDLE && start_ok && i_wr_stb) |=> o_busy ##16 o_busy ##1 !o_busy)
    else $error("write busy window wrong");
  a_rd_busy: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R11
    (state_q == ST_IDLE && start_ok && i_rd_stb) |=> o_busy ##16 o_busy ##1 !o_busy)
    else $error("read busy window wrong");
  a_xfer_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R10, see R11
    (state_q == ST_WR || state_q == ST_RD) |-> o_busy && (xfer_age_q <= 5'h10))
    else $error("busy dropped or transfer overran");
  a_rd_valid: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R12
    ((state_q == ST_RD) && last_step) |=> o_data_valid && !o_busy ##1 !o_data_valid)
    else $error("read valid not flagged once");
  a_busy_ignore: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R20
    ((state_q == ST_WR || state_q == ST_RD) && !last_step && (i_wr_stb || i_rd_stb))
    |=> (state_q == $past(state_q)))
    else $error("strobe during busy took effect");
  a_tx_only_wr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R04
    (mem_we && dir_q == `ALSR_DIR_TX) |-> merged[5:0] == old_set[5:0])
    else $error("transmit-only write touched receive fields");
  a_tx_only_rd: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // see R04
    ((state_q == ST_RD) && last_step && dir_q == `ALSR_DIR_TX) |=> $stable(o_rx_eq)
    && $stable(o_dc_gain))
    else $error("transmit-only read changed receive outputs");
  a_axi_bhold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_bvalid && !i_bready) |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before taken");
  c_write: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) mem_we);
  c_read: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n) o_data_valid);
  c_tx_only: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    mem_we && dir_q == `ALSR_DIR_TX);
  c_axi_wr: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_bvalid && i_bready);
endmodule // alsr_reconfig

// file: alsr_fabric_model.sv
// Purpose: fabric requester model for channel setting writes and reads
// Assumes: synchronous to i_sys_clk, requests come from hierarchical op calls
// Notes: kind 2 and poke break the request rules on purpose, only when asked
`timescale 1ns/1ps
`include "alsr_consts.svh"
module alsr_fabric_model (
  // clock
  input wire logic i_sys_clk,
  // controller status
  input wire logic i_busy,
  input wire logic i_data_valid,
  // request lines
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [`ALSR_IDX_W-1:0] o_chan_idx,
  output logic [1:0] o_dir_sel,
  output logic [`ALSR_SWING_W-1:0] o_output_swing,
  output logic [`ALSR_PREEMP_W-1:0] o_preemp,
  output logic [`ALSR_DCG_W-1:0] o_dc_gain,
  output logic [`ALSR_EQ_W-1:0] o_rx_eq
);
  // idle request lines
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_chan_idx = 2'h0;
    o_dir_sel = 2'h0;
    {o_output_swing, o_preemp, o_dc_gain, o_rx_eq} = 14'h0000;
  end
  // kind 0 write, 1 read, 2 both strobes; poke re-strobes at that busy cycle
  task automatic op(input int kind, input logic [1:0] idx, input logic [1:0] dir,
      input logic [13:0] val, input int poke, output int cnt, output logic dvf,
      output logic dvn);
    int n;
    logic s;
    cnt = 0;
    // a strobe during busy would be dropped, so wait it out
    for (n = 0; n < 100 && i_busy !== 1'b0; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    @(posedge i_sys_clk);
    o_chan_idx <= idx;
    o_dir_sel <= dir;
    {o_output_swing, o_preemp, o_dc_gain, o_rx_eq} <= val;
    o_wr_stb <= (kind != 1);
    o_rd_stb <= (kind != 0);
    // strobe drops after one cycle; values held until busy falls
    for (n = 0; n < 40; n++) begin
      @(posedge i_sys_clk);
      s = (poke > 0 && cnt == poke);
      o_wr_stb <= s && kind == 0;
      o_rd_stb <= s && kind == 1;
      o_chan_idx <= s ? idx ^ 2'h1 : idx;
      #1;
      if (i_busy !== 1'b1) break;
      cnt++;
    end
    dvf = i_data_valid;
    // values no longer owed: show the inverse, not a stale copy
    @(posedge i_sys_clk);
    {o_output_swing, o_preemp, o_dc_gain, o_rx_eq} <= ~val;
    #1;
    dvn = i_data_valid;
  endtask
endmodule // alsr_fabric_model

// file: tb_top.sv
// Purpose: self-checking bench for the analog lane setting controller
// Assumes: fabric model on the request side, AXI4-Lite tasks for registers
// Notes: expectations come from a per-channel shadow kept here
`timescale 1ns/1ps
`include "alsr_consts.svh"
module tb_top;
  logic clk, rst_n;
  // axi master side
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  // fabric side
  logic wr_stb, rd_stb, busy, dv;
  logic [1:0] idx, dir, dg, dg_o;
  logic [2:0] sw, sw_o;
  logic [4:0] pe, pe_o;
  logic [3:0] eq, eq_o;
  // shadow of channel words and of the read-back outputs
  logic [13:0] chan_q [4];
  logic [13:0] rb;
  logic [1:0] dirs [4];
  int num_errors, comparisons, wr_cnt, rd_cnt, n, c;

  alsr_reconfig alsr_reconfig_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wr_stb(wr_stb),
    .i_rd_stb(rd_stb), .i_chan_idx(idx), .i_dir_sel(dir), .i_output_swing(sw),
    .i_preemp(pe), .i_dc_gain(dg), .i_rx_eq(eq), .o_busy(busy), .o_data_valid(dv),
    .o_output_swing(sw_o), .o_preemp(pe_o), .o_dc_gain(dg_o), .o_rx_eq(eq_o),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  alsr_fabric_model alsr_fabric_model_i (.i_sys_clk(clk), .i_busy(busy),
    .i_data_valid(dv), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb), .o_chan_idx(idx),
    .o_dir_sel(dir), .o_output_swing(sw), .o_preemp(pe), .o_dc_gain(dg), .o_rx_eq(eq));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("wait limit used up at t=%0t", $time);
    close_out();
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s ended, mismatches %0d", name, num_errors);
  endtask
  // axi write: offer both channels, drop each once taken, hold bready to answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        awaddr <= ~a;
        wdata <= ~v;
        ok = 1'b1;
      end
    end
    if (!ok) timeout();
    #1;
  endtask
  // axi read: address until taken, rready until rvalid
  task automatic axi_rd(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        araddr <= ~a;
        ok = 1'b1;
      end
    end
    if (!ok) timeout();
    #1;
  endtask
  // one fabric request; taken says whether the controller must act on it
  task automatic fab(input int kind, input logic [1:0] ch, input logic [1:0] ds,
      input logic [13:0] val, input int poke, input logic taken);
    int cnt;
    logic dvf, dvn;
    alsr_fabric_model_i.op(kind, ch, ds, val, poke, cnt, dvf, dvn);
    chk(cnt, taken ? 32'h11 : 32'h0);
    chk(dvf, taken && kind == 1);
    chk(dvn, 1'b0);
    if (taken && kind == 0) begin
      if (ds != 2'h1) chan_q[ch][13:6] = val[13:6];
      if (ds != 2'h2) chan_q[ch][5:0] = val[5:0];
      wr_cnt++;
    end
    if (taken && kind == 1) begin
      if (ds != 2'h1) rb[13:6] = chan_q[ch][13:6];
      if (ds != 2'h2) rb[5:0] = chan_q[ch][5:0];
      rd_cnt++;
    end
    chk({sw_o, pe_o, dg_o, eq_o}, rb);
  endtask

  initial begin
    rst_n = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {num_errors, comparisons, wr_cnt, rd_cnt} = '0;
    chan_q = '{default: 14'h0000};
    rb = 14'h0000;
    dirs = '{2'h2, 2'h1, 2'h0, 2'h3};
    repeat (4) @(posedge clk);
    #1;
    chk({busy, dv, sw_o, pe_o, dg_o, eq_o}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(busy, 1'b0);
    @(posedge clk);
    #1;
    for (c = 0; c < 40 && busy === 1'b1; c++) begin
      @(posedge clk);
      #1;
    end
    chk(c, 32'h10);
    done("power-up");
    // register map: reset values, read-only status, unmapped offset
    axi_rd(`ALSR_OFF_CTRL);
    chk({d, r}, {32'h1, `ALSR_RESP_OKAY});
    axi_wr(`ALSR_OFF_STATUS, 32'hFFFFFFFF);
    chk(r, `ALSR_RESP_OKAY);
    axi_rd(`ALSR_OFF_STATUS);
    chk(d[6:0], 7'h22);
    axi_wr(8'h10, 32'h1);
    chk(r, `ALSR_RESP_SLVERR);
    axi_rd(8'h10);
    chk({d, r}, {32'h0, `ALSR_RESP_SLVERR});
    done("registers");
    // every select code, back-to-back, then full and partial reads
    for (int i = 0; i < 4; i++) fab(0, i[1:0], dirs[i], 14'h2AC7 + 14'h0513 * i, 0, 1);
    for (int i = 0; i < 4; i++) fab(1, i[1:0], 2'h0, 14'h0000, 0, 1);
    fab(1, 2'h0, 2'h2, 14'h0000, 0, 1);
    fab(1, 2'h3, 2'h1, 14'h0000, 0, 1);
    done("select codes");
    // strobes during busy, or both strobes at once, must not start a transfer on the neighbour
    fab(0, 2'h0, 2'h3, 14'h1234, 5, 1);
    fab(1, 2'h2, 2'h0, 14'h0000, 3, 1);
    fab(1, 2'h1, 2'h0, 14'h0000, 0, 1);
    fab(1, 2'h0, 2'h0, 14'h0000, 0, 1);
    fab(2, 2'h3, 2'h3, 14'h3FFF, 0, 0);
    fab(1, 2'h3, 2'h0, 14'h0000, 0, 1);
    done("refused strobes");
    // fabric strobes disabled through the control register
    axi_wr(`ALSR_OFF_CTRL, 32'h0);
    fab(0, 2'h2, 2'h3, 14'h0F0F, 0, 0);
    fab(1, 2'h2, 2'h3, 14'h0000, 0, 0);
    axi_wr(`ALSR_OFF_CTRL, 32'h1);
    fab(1, 2'h2, 2'h3, 14'h0000, 0, 1);
    axi_rd(`ALSR_OFF_WRCNT);
    chk(d[15:0], wr_cnt[15:0]);
    axi_rd(`ALSR_OFF_RDCNT);
    chk(d[15:0], rd_cnt[15:0]);
    done("enable and counters");
    // mid-run reset clears stored words and counters
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({busy, dv, sw_o, pe_o, dg_o, eq_o}, 32'h0);
    @(posedge clk);
    #1;
    for (c = 0; c < 40 && busy === 1'b1; c++) begin
      @(posedge clk);
      #1;
    end
    chk(c, 32'h10);
    chan_q = '{default: 14'h0000};
    rb = 14'h0000;
    fab(1, 2'h1, 2'h0, 14'h0000, 0, 1);
    axi_rd(`ALSR_OFF_WRCNT);
    chk(d[15:0], 16'h0000);
    done("mid-run reset");
    close_out();
  end
endmodule // tb_top
